// ===== rtl/epp_pkg.sv
// constants shared by the serial programming port and its helpers
// assumes one 50 MHz clock domain; nothing here holds state
package epp_pkg;
    // ------------------------------------------------------------
    // entry opcode and serial word layout
    // ------------------------------------------------------------
    localparam int ENTRY_BITS = 10;
    localparam logic [9:0] ENTRY_OPCODE = 10'h34B;
    localparam int WORD_BITS = 32;
    localparam int CMD_DATA_SEL_BIT = 29;
    localparam int CMD_CODE_SEL_BIT = 28;
    localparam int CMD_READ_BIT = 24;
    localparam int CMD_ADDR_MSB = 18;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_BYTE_MSB = 7;
    localparam int ADDR_BITS = CMD_ADDR_MSB - CMD_ADDR_LSB + 1;
    // ------------------------------------------------------------
    // memory sizes and timing
    // ------------------------------------------------------------
    localparam int DATA_DEPTH = 64;
    localparam int CODE_DEPTH = 2048;
    localparam int CLK_PERIOD_NS = 20;
    localparam int WRITE_TIME_NS = 100000;
    localparam int WRITE_CYCLES = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRTIME_BITS = 24;
    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_WRTIME = 8'h08;
    localparam logic [7:0] REG_LASTCMD = 8'h0C;
    localparam int ST_PROG_BIT = 0;
    localparam int ST_READY_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_ENTRY_BIT = 3;
    localparam int CTRL_ENTRY_EN_BIT = 0;
    localparam logic CTRL_ENTRY_EN_RST = 1'b1;
    // ------------------------------------------------------------
    // protocol states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        EPP_IDLE,
        EPP_SHIFT,
        EPP_LAUNCH,
        EPP_WAIT,
        EPP_DONE
    } epp_state_t;
endpackage

// ===== rtl/epp_mem_if.sv
// request and answer wires between the protocol engine and the memories
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface epp_mem_if;
    logic req;
    logic wr;
    logic sel_code;
    logic [epp_pkg::ADDR_BITS-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
    logic busy;
    logic [epp_pkg::WRTIME_BITS-1:0] wr_cycles;
    modport engine (output req, wr, sel_code, addr, wdata, wr_cycles,
                    input rdata, done, busy);
    modport store (input req, wr, sel_code, addr, wdata, wr_cycles,
                   output rdata, done, busy);
endinterface

// ===== rtl/epp_pin_sync.sv
// two-flop synchronisers for the programming pins, plus clock edge finder
// assumes the pins are asynchronous to clk_i
`timescale 1ns/1ps
module epp_pin_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // raw pins
    input wire logic pin_clock_i,
    input wire logic pin_in_i,
    input wire logic pin_strobe_i,
    // synchronised view
    output logic data_o,
    output logic strobe_o,
    output logic rise_o
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic clk_last_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 3'h0;
            sync_q <= 3'h0;
        end else begin
            meta_q <= {pin_strobe_i, pin_in_i, pin_clock_i};
            sync_q <= meta_q;
        end
    end

    // edge finder looks only at the second stage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_last_q <= 1'b0;
        end else begin
            clk_last_q <= sync_q[0];
        end
    end

    assign rise_o = sync_q[0] & ~clk_last_q;
    assign data_o = sync_q[1];
    assign strobe_o = sync_q[2];
endmodule

// ===== rtl/epp_nvm.sv
// data and code nonvolatile arrays with a timed write
// assumes one request at a time; a new request waits for done
`timescale 1ns/1ps
module epp_nvm #(
    parameter int DATA_DEPTH = epp_pkg::DATA_DEPTH,
    parameter int CODE_DEPTH = epp_pkg::CODE_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // engine side
    epp_mem_if.store mem
);
    logic [7:0] data_mem [DATA_DEPTH];
    logic [7:0] code_mem [CODE_DEPTH];
    logic [epp_pkg::WRTIME_BITS-1:0] cnt_q;
    logic busy_q;
    logic done_q;
    logic [7:0] rdata_q;

    if (DATA_DEPTH < 1 || CODE_DEPTH < 1 || CODE_DEPTH > (1 << epp_pkg::ADDR_BITS)) begin : g_chk
        $error("epp_nvm: depth out of range");
    end

    // same address field as normal operation, folded onto each array
    always_ff @(posedge clk_i) begin
        if (mem.req && mem.wr && !busy_q) begin
            if (mem.sel_code) begin
                code_mem[mem.addr % CODE_DEPTH] <= mem.wdata;
            end else begin
                data_mem[mem.addr % DATA_DEPTH] <= mem.wdata;
            end
        end
    end

    // write stays busy for the programmed cell time
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            done_q <= 1'b0;
            if (busy_q) begin
                if (cnt_q <= 24'h000001) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
                cnt_q <= cnt_q - 24'h000001;
            end else if (mem.req && mem.wr) begin
                busy_q <= 1'b1;
                cnt_q <= mem.wr_cycles;
            end else if (mem.req) begin
                rdata_q <= mem.sel_code ? code_mem[mem.addr % CODE_DEPTH]
                                        : data_mem[mem.addr % DATA_DEPTH];
                done_q <= 1'b1;
            end
        end
    end

    assign mem.busy = busy_q;
    assign mem.done = done_q;
    assign mem.rdata = rdata_q;
endmodule

// ===== rtl/epp_port.sv
// serial in-circuit programming port with an AHB-Lite status window
// assumes reset_seq_i is high while the internal reset sequence runs,
// and that rst_n_i is the power-on reset, so program mode ends with power
`timescale 1ns/1ps
module epp_port #(
    parameter int WRITE_CYCLES = epp_pkg::WRITE_CYCLES,
    parameter int DATA_DEPTH = epp_pkg::DATA_DEPTH,
    parameter int CODE_DEPTH = epp_pkg::CODE_DEPTH
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // reset sequencer
    input wire logic reset_seq_i,
    // programming pins
    input wire logic port_pin_clock_i,
    input wire logic port_pin_in_i,
    input wire logic port_pin_strobe_i,
    output logic port_pin_out_o,
    output logic port_pin_out_oe_o,
    // mode flag to the core
    output logic prog_mode_o,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o
);
    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (WRITE_CYCLES < 1 || WRITE_CYCLES >= (1 << epp_pkg::WRTIME_BITS)) begin : g_chk
        $error("epp_port: WRITE_CYCLES out of range");
    end

    localparam logic [epp_pkg::WRTIME_BITS-1:0] WRTIME_RST =
        (epp_pkg::WRTIME_BITS)'(WRITE_CYCLES);

    // ------------------------------------------------------------
    // pins and memories
    // ------------------------------------------------------------
    logic sin;
    logic strobe;
    logic rise;
    epp_mem_if mem_bus ();

    epp_pin_sync u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .pin_clock_i(port_pin_clock_i),
        .pin_in_i(port_pin_in_i),
        .pin_strobe_i(port_pin_strobe_i),
        .data_o(sin),
        .strobe_o(strobe),
        .rise_o(rise)
    );

    epp_nvm #(
        .DATA_DEPTH(DATA_DEPTH),
        .CODE_DEPTH(CODE_DEPTH)
    ) u_nvm (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .mem(mem_bus.store)
    );

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic entry_en_q;
    logic [epp_pkg::WRTIME_BITS-1:0] wrtime_q;
    logic [epp_pkg::ENTRY_BITS-1:0] entry_sr_q;
    logic entry_seen_q;
    logic prog_q;
    logic active;
    epp_pkg::epp_state_t state_q;
    logic [epp_pkg::WORD_BITS-1:0] cmd_q;
    logic [epp_pkg::WORD_BITS-1:0] resp_q;
    logic [epp_pkg::WORD_BITS-1:0] last_cmd_q;
    logic sout_q;
    logic low_edges_q;
    logic ready_q;
    logic req_q;
    logic cmd_read;
    logic cmd_data;
    logic cmd_code;
    logic cmd_valid;

    // decode of the word just shifted in
    assign cmd_read = cmd_q[epp_pkg::CMD_READ_BIT];
    assign cmd_data = cmd_q[epp_pkg::CMD_DATA_SEL_BIT];
    assign cmd_code = cmd_q[epp_pkg::CMD_CODE_SEL_BIT];
    // both or neither target bit set: no access, the byte echoes as is
    assign cmd_valid = cmd_data ^ cmd_code;

    // engine only runs once reset has finished with the flag set
    assign active = prog_q && !reset_seq_i;

    // ------------------------------------------------------------
    // entry opcode detection
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            entry_sr_q <= '0;
        end else if (!reset_seq_i) begin
            entry_sr_q <= '0;
        end else if (rise) begin
            entry_sr_q <= {entry_sr_q[epp_pkg::ENTRY_BITS-2:0], sin};
        end
    end

    // a pattern landing after the sequence has ended never counts
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            entry_seen_q <= 1'b0;
        end else if (reset_seq_i && entry_en_q &&
                     entry_sr_q == epp_pkg::ENTRY_OPCODE) begin
            entry_seen_q <= 1'b1;
        end
    end

    // only the power-on reset clears the mode; pin resets do not
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prog_q <= 1'b0;
        end else if (entry_seen_q) begin
            prog_q <= 1'b1;
        end
    end

    assign prog_mode_o = prog_q;

    // ------------------------------------------------------------
    // command and response shifting
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= epp_pkg::EPP_IDLE;
            low_edges_q <= 1'b0;
            req_q <= 1'b0;
        end else begin
            req_q <= 1'b0;
            case (state_q)
                epp_pkg::EPP_IDLE: begin
                    if (active && strobe) begin
                        state_q <= epp_pkg::EPP_SHIFT;
                    end
                end
                epp_pkg::EPP_SHIFT: begin
                    if (!strobe) begin
                        state_q <= epp_pkg::EPP_LAUNCH;
                        low_edges_q <= 1'b0;
                    end
                end
                epp_pkg::EPP_LAUNCH: begin
                    if (strobe) begin
                        state_q <= epp_pkg::EPP_SHIFT;
                    end else if (rise && !low_edges_q) begin
                        low_edges_q <= 1'b1;
                    end else if (rise) begin
                        state_q <= epp_pkg::EPP_WAIT;
                        req_q <= cmd_valid;
                    end
                end
                epp_pkg::EPP_WAIT: begin
                    if (!cmd_valid || (mem_bus.done && !req_q)) begin
                        state_q <= epp_pkg::EPP_DONE;
                    end
                end
                epp_pkg::EPP_DONE: begin
                    // new command only after the output went high again
                    if (strobe) begin
                        state_q <= epp_pkg::EPP_SHIFT;
                    end
                end
                default: begin
                    state_q <= epp_pkg::EPP_IDLE;
                end
            endcase
        end
    end

    // command word, bit 31 enters first and ends at the top
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_q <= '0;
        end else if (active && strobe && rise &&
                     (state_q == epp_pkg::EPP_SHIFT || state_q == epp_pkg::EPP_IDLE ||
                      state_q == epp_pkg::EPP_DONE)) begin
            cmd_q <= {cmd_q[epp_pkg::WORD_BITS-2:0], sin};
        end
    end

    // response word; starts as zero, which the programmer must discard
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            resp_q <= '0;
        end else if (active && strobe && rise) begin
            resp_q <= {resp_q[epp_pkg::WORD_BITS-2:0], 1'b0};
        end else if (state_q == epp_pkg::EPP_LAUNCH && rise && low_edges_q) begin
            // echo the command; address field comes back unchanged
            resp_q <= cmd_q;
        end else if (state_q == epp_pkg::EPP_WAIT && mem_bus.done && cmd_read) begin
            resp_q[epp_pkg::CMD_BYTE_MSB:0] <= mem_bus.rdata;
        end
    end

    // serial output: data bits while loading, busy low while executing
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sout_q <= 1'b1;
        end else if (!active) begin
            sout_q <= 1'b1;
        end else if (strobe && rise) begin
            sout_q <= resp_q[epp_pkg::WORD_BITS-1];
        end else if (state_q == epp_pkg::EPP_LAUNCH && rise) begin
            sout_q <= 1'b0;
        end else if (state_q == epp_pkg::EPP_WAIT &&
                     (!cmd_valid || (mem_bus.done && !req_q))) begin
            sout_q <= 1'b1;
        end
    end

    assign port_pin_out_o = sout_q;
    assign port_pin_out_oe_o = active;

    // ready flag: set on completion, cleared when the next launch starts
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_q <= 1'b0;
        end else if (state_q == epp_pkg::EPP_WAIT &&
                     (!cmd_valid || (mem_bus.done && !req_q))) begin
            ready_q <= 1'b1;
        end else if (state_q == epp_pkg::EPP_LAUNCH && rise && low_edges_q) begin
            ready_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            last_cmd_q <= '0;
        end else if (state_q == epp_pkg::EPP_LAUNCH && rise && low_edges_q) begin
            last_cmd_q <= cmd_q;
        end
    end

    // ------------------------------------------------------------
    // memory request
    // ------------------------------------------------------------
    assign mem_bus.req = req_q;
    assign mem_bus.wr = !cmd_read;
    assign mem_bus.sel_code = cmd_code;
    assign mem_bus.addr = cmd_q[epp_pkg::CMD_ADDR_MSB:epp_pkg::CMD_ADDR_LSB];
    assign mem_bus.wdata = cmd_q[epp_pkg::CMD_BYTE_MSB:0];
    assign mem_bus.wr_cycles = wrtime_q;

    // ------------------------------------------------------------
    // ahb-lite slave, zero wait states, always OKAY
    // ------------------------------------------------------------
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic addr_phase;

    assign addr_phase = hsel_i && hready_i && htrans_i[1];
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_phase && hwrite_i;
            if (addr_phase) begin
                wr_addr_q <= haddr_i[7:0];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            entry_en_q <= epp_pkg::CTRL_ENTRY_EN_RST;
            wrtime_q <= WRTIME_RST;
        end else if (wr_pend_q) begin
            if (wr_addr_q == epp_pkg::REG_CTRL) begin
                entry_en_q <= hwdata_i[epp_pkg::CTRL_ENTRY_EN_BIT];
            end else if (wr_addr_q == epp_pkg::REG_WRTIME && hwdata_i[23:0] != 24'h000000) begin
                // a zero cell time would end a write after one cycle, the same as one, so it is refused
                wrtime_q <= hwdata_i[epp_pkg::WRTIME_BITS-1:0];
            end
        end
    end

    // read data captured in the address phase, shown in the data phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_o <= 32'h00000000;
        end else if (addr_phase && !hwrite_i) begin
            case (haddr_i[7:0])
                epp_pkg::REG_STATUS: begin
                    hrdata_o <= 32'h00000000;
                    hrdata_o[epp_pkg::ST_PROG_BIT] <= prog_q;
                    hrdata_o[epp_pkg::ST_READY_BIT] <= ready_q;
                    hrdata_o[epp_pkg::ST_BUSY_BIT] <= mem_bus.busy;
                    hrdata_o[epp_pkg::ST_ENTRY_BIT] <= entry_seen_q;
                end
                epp_pkg::REG_CTRL: begin
                    hrdata_o <= {31'h00000000, entry_en_q};
                end
                epp_pkg::REG_WRTIME: begin
                    hrdata_o <= {8'h00, wrtime_q};
                end
                epp_pkg::REG_LASTCMD: begin
                    hrdata_o <= last_cmd_q;
                end
                default: begin
                    hrdata_o <= 32'h00000000;
                end
            endcase
        end
    end

    logic unused_ok;
    assign unused_ok = &{1'b0, hsize_i, haddr_i[31:8], mem_bus.busy};
endmodule

// ===== dv/epp_port_props.sv
// assertions on the serial programming port, top ports only
// assumes one clk_i domain and WRITE_CYCLES as set on the port
`timescale 1ns/1ps
module epp_port_props #(
    parameter int WRITE_CYCLES = 20
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // watched ports
    input wire logic reset_seq_i,
    input wire logic port_pin_clock_i,
    input wire logic port_pin_strobe_i,
    input wire logic port_pin_out_o,
    input wire logic port_pin_out_oe_o,
    input wire logic prog_mode_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----------------
    // helper counters
    // ----------------
    logic clk_q;
    logic [3:0] since_q;
    logic [15:0] busy_q;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk_q <= 1'b0;
            since_q <= 4'hF;
        end else begin
            clk_q <= port_pin_clock_i;
            if (port_pin_clock_i && !clk_q) begin
                since_q <= 4'h0;
            end else if (since_q != 4'hF) begin
                since_q <= since_q + 4'h1;
            end
        end
    end
    // busy stretch counted so a stuck-low output is caught
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_q <= 16'h0;
        end else begin
            busy_q <= (!port_pin_out_o && !port_pin_strobe_i) ? busy_q + 16'h1 : 16'h0;
        end
    end
    // ----------------
    // properties
    // ----------------
    sequence s_released;
        prog_mode_o && !port_pin_strobe_i && $rose(port_pin_out_o);
    endsequence
    property p_mode_hold; prog_mode_o |=> prog_mode_o; endproperty
    property p_entry_win; $rose(prog_mode_o) |-> $past(reset_seq_i); endproperty
    property p_entry_edge; $rose(prog_mode_o) |-> since_q < 4'h8; endproperty
    property p_oe; port_pin_out_oe_o == (prog_mode_o && !reset_seq_i); endproperty
    property p_idle; !prog_mode_o |-> port_pin_out_o; endproperty
    property p_busy; busy_q < 16'(WRITE_CYCLES + 40); endproperty
    property p_ready; s_released |=> port_pin_out_o [*2]; endproperty
    property p_shift; $changed(port_pin_out_o) && port_pin_strobe_i |-> since_q < 4'h8;
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode dropped");
    a_entry_win: assert property (p_entry_win) else $error("late entry");
    a_entry_edge: assert property (p_entry_edge) else $error("entry w/o edge");
    a_oe: assert property (p_oe) else $error("oe wrong");
    a_idle: assert property (p_idle) else $error("out moved w/o mode");
    a_busy: assert property (p_busy) else $error("busy too long");
    a_ready: assert property (p_ready) else $error("ready not held");
    a_shift: assert property (p_shift) else $error("out w/o clock");
endmodule
bind epp_port epp_port_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
    .clk_i, .rst_n_i, .reset_seq_i, .port_pin_clock_i, .port_pin_strobe_i,
    .port_pin_out_o, .port_pin_out_oe_o, .prog_mode_o
);

// ===== dv/epp_prog_model.sv
// programmer model driving three programming pins and reading the fourth
// assumes a 160 ns link clock that stands low outside frames
`timescale 1ns/1ps
module epp_prog_model (
    // pins towards the device
    input wire logic port_pin_out_i,
    output logic port_pin_clock_o,
    output logic port_pin_in_o,
    output logic port_pin_strobe_o
);
    initial begin
        port_pin_clock_o = 1'b0;
        port_pin_in_o = 1'b0;
        port_pin_strobe_o = 1'b0;
    end
    // out sampled late in the period, the edge itself is too early
    task automatic shift(input logic [31:0] w, input int n, output logic [31:0] r);
        r = 32'h0;
        for (int i = n - 1; i >= 0; i--) begin
            port_pin_in_o <= w[i];
            #40 port_pin_clock_o <= 1'b1;
            #80 port_pin_clock_o <= 1'b0;
            #38 r = {r[30:0], port_pin_out_i};
            #2;
        end
        port_pin_in_o <= ~port_pin_in_o;
    endtask
    task automatic entry(input logic [9:0] op);
        logic [31:0] r;
        shift({22'h0, op}, 10, r);
    endtask
    task automatic cmd(input logic [31:0] w, output logic [31:0] r, output logic busy);
        port_pin_strobe_o <= 1'b1;
        #80 shift(w, 32, r);
        port_pin_strobe_o <= 1'b0;
        #80 port_pin_clock_o <= 1'b1;
        #80 port_pin_clock_o <= 1'b0;
        #78 busy = port_pin_out_i;
        #2 port_pin_clock_o <= 1'b1;
        #80 port_pin_clock_o <= 1'b0;
        // no limit of its own: the bench watchdog ends a hang
        while (port_pin_out_i !== 1'b1) begin
            #20;
        end
    endtask
endmodule

// ===== dv/tb.sv
// self-checking bench for the serial programming port
// assumes the programmer model owns the pins, the bench owns the bus
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reset_seq_i = 1'b1;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o;
    logic hreadyout_o, hresp_o, pclk, pin, pstb, pout, poe, prog_mode_o;
    int errors = 0;
    int checked = 0;
    // line pulled high by the programmer while the device is off it
    wire pwire = poe ? pout : 1'b1;
    epp_port #(.WRITE_CYCLES(20)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .reset_seq_i(reset_seq_i),
        .port_pin_clock_i(pclk), .port_pin_in_i(pin), .port_pin_strobe_i(pstb),
        .port_pin_out_o(pout), .port_pin_out_oe_o(poe), .prog_mode_o(prog_mode_o),
        .hsel_i(1'b1), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o)
    );
    epp_prog_model prog (
        .port_pin_out_i(pwire), .port_pin_clock_o(pclk), .port_pin_in_o(pin),
        .port_pin_strobe_o(pstb)
    );
    initial forever #10 clk_i = ~clk_i;
    // ----------------
    // shared tasks
    // ----------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge clk_i);
        htrans_i <= 2'h2;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
        chk({31'h0, hresp_o}, 32'h0, "hresp");
    endtask
    task automatic power_up();
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        reset_seq_i <= 1'b1;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_entry();
        power_up();
        repeat (3) @(posedge clk_i);
        prog.entry(epp_pkg::ENTRY_OPCODE);
        repeat (6) @(posedge clk_i);
        chk({31'h0, prog_mode_o}, 32'h1, "mode");
        chk({31'h0, poe}, 32'h0, "oe in reset");
        reset_seq_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk({31'h0, poe}, 32'h1, "oe");
        $display("entry done");
    endtask
    // reserved bits kept zero in every command word
    task automatic t_cmds();
        logic [31:0] c [7] = '{32'h2000_05A5, 32'h1007_FF3C, 32'h2100_0500,
            32'h1107_FF00, 32'h2000_3F5A, 32'h2100_3F00, 32'h2100_0500};
        logic [7:0] b [6] = '{8'hA5, 8'h3C, 8'hA5, 8'h3C, 8'h5A, 8'h5A};
        logic [31:0] r;
        logic [31:0] st;
        logic busy;
        ahb(1'b1, epp_pkg::REG_WRTIME, 32'h0000_0019, r);
        ahb(1'b0, epp_pkg::REG_WRTIME, 32'h0, r);
        chk(r, 32'h0000_0019, "wrtime");
        ahb(1'b0, 8'h40, 32'h0, r);
        chk(r, 32'h0, "unmapped");
        for (int i = 0; i < 7; i++) begin
            prog.cmd(c[i], r, busy); // first answer ignored
            if (i > 0) chk(r, {c[i-1][31:8], b[i-1]}, "resp");
            chk({31'h0, busy}, 32'h0, "busy");
            ahb(1'b0, epp_pkg::REG_STATUS, 32'h0, st);
            chk({28'h0, st[3:0]}, 32'hB, "status");
        end
        ahb(1'b0, epp_pkg::REG_LASTCMD, 32'h0, r);
        chk(r, c[6], "lastcmd");
        $display("commands done");
    endtask
    task automatic t_no_entry();
        logic [31:0] r;
        logic busy;
        power_up();
        chk({31'h0, prog_mode_o}, 32'h0, "mode after power");
        prog.entry(10'h34A);
        // entry detection switched off: a good opcode must not count
        ahb(1'b1, epp_pkg::REG_CTRL, 32'h0, r);
        prog.entry(epp_pkg::ENTRY_OPCODE);
        ahb(1'b0, epp_pkg::REG_CTRL, 32'h0, r);
        chk(r, 32'h0, "ctrl");
        @(posedge clk_i);
        reset_seq_i <= 1'b0;
        prog.entry(epp_pkg::ENTRY_OPCODE); // too late to count
        prog.cmd(32'h2000_0511, r, busy);
        chk({30'h0, prog_mode_o, poe}, 32'h0, "no mode");
        chk({31'h0, busy}, 32'h1, "no busy");
        $display("no entry done");
    endtask
    initial begin
        t_entry();
        t_cmds();
        t_no_entry();
        report_and_stop();
    end
    // tests need about 60 us; ten times that means a hang
    initial begin
        #600000;
        errors++;
        $display("[FAIL] %0t watchdog", $time);
        report_and_stop();
    end
endmodule
